// file: design/mtam_defines.svh
// Function
// - Pointers are offsets within 8K/16K dual-port RAM
// - Parameter pages sit at 256-byte spacing
// - Multichannel mode keeps shared globals in page
// - Equal start pointers give one shared table
// - One 32-bit slot entry: mask, valid, channel
// - Separate receive and transmit current-slot pointers
// - Channel address: six entry bits, six zeros
// - One channel area serves both directions
// - Equal channel pointers concatenate slots
// - Queue address is table base plus offset
// - At most 16384 descriptors per controller
// - Descriptor queues are circular, programmable start, length
// - Fetch 32-bit data buffer pointer from descriptor
// - Buffer length up to 64K from descriptor
`ifndef MTAM_DEFINES_SVH
`define MTAM_DEFINES_SVH

`define MTAM_REG_CTRL 16'h0000
`define MTAM_REG_PAGE 16'h0004
`define MTAM_REG_RXSTART 16'h0008
`define MTAM_REG_TXSTART 16'h000C
`define MTAM_REG_STATUS 16'h0010
`define MTAM_REG_SLOTS 16'h0014
`define MTAM_REG_SKIPS 16'h0018
`define MTAM_REG_RXSLOT 16'h001C
`define MTAM_REG_TXSLOT 16'h0020
`define MTAM_DPR_SEL_BIT 15

`define MTAM_CTRL_EN 0
`define MTAM_CTRL_LARGE 1
`define MTAM_STAT_OVR_RX 2
`define MTAM_STAT_OVR_TX 3

`define MTAM_DPR_SMALL_MASK 14'h1FFF
`define MTAM_DPR_LARGE_MASK 14'h3FFF
`define MTAM_PAGE_SHIFT 8
`define MTAM_RX_TABLE_RST 14'h0014
`define MTAM_TX_TABLE_RST 14'h003C

`define MTAM_TSE_VALID 15
`define MTAM_TSE_CHAN_LSB 6
`define MTAM_TSE_MASK_LSB 24

`define MTAM_GLB_DESC_BASE 14'h0000
`define MTAM_CH_OFS 14'h0000
`define MTAM_CH_IDX 14'h0004
`define MTAM_CH_LEN 14'h0008
`define MTAM_BD_BYTES 16'h0008
`define MTAM_BD_PTR_OFS 32'h00000004
`define MTAM_SLOT_STEP 14'h0004

`endif

// file: design/mtam_pkg.sv
package mtam_pkg;
   typedef enum logic [3:0] {
      ST_IDLE,
      ST_TSE,
      ST_TSE_W,
      ST_FETCH,
      ST_FETCH_W,
      ST_WBACK,
      ST_BD_LEN,
      ST_BD_PTR
   } mtam_state_t;
endpackage

// file: design/mtam_dpr.sv
`timescale 1ns/1ps
module mtam_dpr #(
   parameter int AW = 12,
   parameter int DW = 32
) (
   input wire logic clk,
   input wire logic ce,
   input wire logic en,
   input wire logic we,
   input wire logic [AW-1:0] addr,
   input wire logic [DW-1:0] wdata,
   output logic [DW-1:0] q
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge clk) begin
      if (ce && en) begin
         if (we) begin
            mem[addr] <= wdata;
         end else begin
            q <= mem[addr];
         end
      end
   end
endmodule // mtam_dpr

// file: design/mtam_slot_track.sv
`timescale 1ns/1ps
`include "mtam_defines.svh"
module mtam_slot_track (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic slotClkPin,
   input wire logic frameSyncPin,
   input wire logic [13:0] startPtr,
   output logic tick,
   output logic [13:0] curPtr
);
   logic clkS1_r, clkS2_r, clkS3_r;
   logic frmS1_r, frmS2_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         clkS1_r <= 1'b0;
         clkS2_r <= 1'b0;
         clkS3_r <= 1'b0;
         frmS1_r <= 1'b0;
         frmS2_r <= 1'b0;
      end else if (ce) begin
         clkS1_r <= slotClkPin;
         clkS2_r <= clkS1_r;
         clkS3_r <= clkS2_r;
         frmS1_r <= frameSyncPin;
         frmS2_r <= frmS1_r;
      end
   end

   // Frame sync at a slot edge restarts the table walk
   always_ff @(posedge clk) begin
      if (rst) begin
         tick <= 1'b0;
         curPtr <= 14'h0000;
      end else if (ce) begin
         tick <= clkS2_r & ~clkS3_r;
         if (clkS2_r && !clkS3_r) begin
            curPtr <= frmS2_r ? startPtr : curPtr + `MTAM_SLOT_STEP;
         end
      end
   end
endmodule // mtam_slot_track

// file: design/mtam_top.sv
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "mtam_defines.svh"
module mtam_top
   import mtam_pkg::*;
#(
   parameter int DPR_AW = 12
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [15:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdData,
   input wire logic rxSlotClk,
   input wire logic rxFrameSync,
   input wire logic txSlotClk,
   input wire logic txFrameSync,
   output logic hostReq,
   output logic [31:0] hostAddr,
   input wire logic hostAck,
   input wire logic [31:0] hostRdData,
   output logic xferValid,
   output logic xferRx,
   output logic [31:0] xferAddr,
   output logic [15:0] xferLen,
   output logic [5:0] xferChan,
   output logic [7:0] xferSubMask,
   output logic busy
);
   logic enable_r, large_r;
   logic [5:0] page_r;
   logic [13:0] rxStart_r, txStart_r;
   logic ovrRx_r, ovrTx_r;
   logic [31:0] slots_r, skips_r;
   logic [31:0] rdData_r;
   logic readMem_r;
   logic rxPend_r, txPend_r;
   mtam_state_t state_r;
   logic dirRx_r;
   logic [13:0] slotPtr_r;
   logic [31:0] entry_r;
   logic [1:0] fetchIdx_r;
   logic [31:0] glbBase_r, offW_r, idxW_r, lenW_r;
   logic [15:0] bufLen_r;

   logic rxTick, txTick;
   logic [13:0] rx_current_slot_pointer, tx_current_slot_pointer;
   logic busMem, regSel;
   logic [13:0] dprMask, pageBase, chanBase, engPtr;
   logic memEn, memWe;
   logic [DPR_AW-1:0] memAddr;
   logic [31:0] memWd, memQ;
   logic [15:0] curOff, curIdx, curLen, nxtIdx;
   logic [31:0] descAddr, idxWb;
   logic engRd, engWr;

   mtam_slot_track u_rxTrack (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .slotClkPin(rxSlotClk),
      .frameSyncPin(rxFrameSync),
      .startPtr(rxStart_r),
      .tick(rxTick),
      .curPtr(rx_current_slot_pointer)
   );

   mtam_slot_track u_txTrack (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .slotClkPin(txSlotClk),
      .frameSyncPin(txFrameSync),
      .startPtr(txStart_r),
      .tick(txTick),
      .curPtr(tx_current_slot_pointer)
   );

   // Shared RAM: bus window and slot engine take turns on one port
   mtam_dpr #(
      .AW(DPR_AW),
      .DW(32)
   ) u_dpr (
      .clk(clk),
      .ce(ce),
      .en(memEn),
      .we(memWe),
      .addr(memAddr),
      .wdata(memWd),
      .q(memQ)
   );

   // Address bit 15 picks the RAM window over the registers
   assign busMem = (regWr | regRd) & regAddr[`MTAM_DPR_SEL_BIT];
   assign regSel = ~regAddr[`MTAM_DPR_SEL_BIT];
   assign dprMask = large_r ? `MTAM_DPR_LARGE_MASK : `MTAM_DPR_SMALL_MASK;
   assign pageBase = {page_r, 8'h00};
   // Twelve-bit channel area address, low six bits forced to zero
   assign chanBase = {2'b00, entry_r[`MTAM_TSE_CHAN_LSB +: 6], 6'b000000};
   // One area per channel; direction only selects a half word
   assign curOff = dirRx_r ? offW_r[15:0] : offW_r[31:16];
   assign curIdx = dirRx_r ? idxW_r[15:0] : idxW_r[31:16];
   assign curLen = dirRx_r ? lenW_r[15:0] : lenW_r[31:16];
   assign nxtIdx = (curIdx + `MTAM_BD_BYTES >= curLen) ? 16'h0000
                 : curIdx + `MTAM_BD_BYTES;
   assign idxWb = dirRx_r ? {idxW_r[31:16], nxtIdx} : {nxtIdx, idxW_r[15:0]};
   // Descriptor table base is long-word aligned; low bits dropped
   assign descAddr = {glbBase_r[31:2], 2'b00} + {16'h0000, curOff}
                   + {16'h0000, curIdx};

   always_comb begin
      engPtr = slotPtr_r;
      case (fetchIdx_r)
         2'd0: engPtr = pageBase + `MTAM_GLB_DESC_BASE;
         2'd1: engPtr = chanBase + `MTAM_CH_OFS;
         2'd2: engPtr = chanBase + `MTAM_CH_IDX;
         default: engPtr = chanBase + `MTAM_CH_LEN;
      endcase
      if (state_r == ST_TSE) begin
         engPtr = slotPtr_r;
      end else if (state_r == ST_WBACK) begin
         engPtr = chanBase + `MTAM_CH_IDX;
      end
   end

   // The engine uses the RAM port only in these states
   assign engRd = (state_r == ST_TSE) || (state_r == ST_FETCH);
   assign engWr = (state_r == ST_WBACK);

   // Bus accesses to the RAM window win; the engine holds its state while they last
   always_comb begin
      memEn = 1'b0;
      memWe = 1'b0;
      memAddr = '0;
      memWd = 32'h00000000;
      if (busMem) begin
         memEn = 1'b1;
         memWe = regWr;
         memAddr = regAddr[DPR_AW+1:2];
         memWd = regWrData;
      end else if (engRd || engWr) begin
         memEn = 1'b1;
         memWe = engWr;
         memAddr = DPR_AW'((engPtr & dprMask) >> 2);
         memWd = idxWb;
      end
   end

   // Control registers
   always_ff @(posedge clk) begin
      if (rst) begin
         enable_r <= 1'b0;
         large_r <= 1'b0;
         page_r <= 6'h00;
         rxStart_r <= `MTAM_RX_TABLE_RST;
         txStart_r <= `MTAM_TX_TABLE_RST;
      end else if (ce && regWr && regSel) begin
         case (regAddr)
            `MTAM_REG_CTRL: begin
               enable_r <= regWrData[`MTAM_CTRL_EN];
               large_r <= regWrData[`MTAM_CTRL_LARGE];
            end
            `MTAM_REG_PAGE: page_r <= regWrData[5:0];
            `MTAM_REG_RXSTART: rxStart_r <= regWrData[13:0];
            `MTAM_REG_TXSTART: txStart_r <= regWrData[13:0];
            default: begin
            end
         endcase
      end
   end

   // Slot events wait here; a new event wins over the take
   always_ff @(posedge clk) begin
      if (rst) begin
         rxPend_r <= 1'b0;
         txPend_r <= 1'b0;
         ovrRx_r <= 1'b0;
         ovrTx_r <= 1'b0;
      end else if (ce) begin
         if (rxTick && enable_r) begin
            rxPend_r <= 1'b1;
         end else if (state_r == ST_IDLE && rxPend_r) begin
            rxPend_r <= 1'b0;
         end
         // Receive is served first; transmit waits for a clear receive queue
         if (txTick && enable_r) begin
            txPend_r <= 1'b1;
         end else if (state_r == ST_IDLE && !rxPend_r && txPend_r) begin
            txPend_r <= 1'b0;
         end
         if (rxTick && enable_r && rxPend_r) begin
            ovrRx_r <= 1'b1;
         end else if (regWr && regSel && regAddr == `MTAM_REG_STATUS
                      && regWrData[`MTAM_STAT_OVR_RX]) begin
            ovrRx_r <= 1'b0;
         end
         if (txTick && enable_r && txPend_r) begin
            ovrTx_r <= 1'b1;
         end else if (regWr && regSel && regAddr == `MTAM_REG_STATUS
                      && regWrData[`MTAM_STAT_OVR_TX]) begin
            ovrTx_r <= 1'b0;
         end
      end
   end

   // Slot walker and descriptor fetch
   always_ff @(posedge clk) begin
      if (rst) begin
         state_r <= ST_IDLE;
         dirRx_r <= 1'b0;
         slotPtr_r <= 14'h0000;
         entry_r <= 32'h00000000;
         fetchIdx_r <= 2'd0;
         glbBase_r <= 32'h00000000;
         offW_r <= 32'h00000000;
         idxW_r <= 32'h00000000;
         lenW_r <= 32'h00000000;
         bufLen_r <= 16'h0000;
         hostReq <= 1'b0;
         hostAddr <= 32'h00000000;
         xferValid <= 1'b0;
         xferRx <= 1'b0;
         xferAddr <= 32'h00000000;
         xferLen <= 16'h0000;
         xferChan <= 6'h00;
         xferSubMask <= 8'h00;
         slots_r <= 32'h00000000;
         skips_r <= 32'h00000000;
      end else if (ce) begin
         xferValid <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               // Receive wins when both directions wait
               if (enable_r && (rxPend_r || txPend_r)) begin
                  dirRx_r <= rxPend_r;
                  slotPtr_r <= rxPend_r ? rx_current_slot_pointer : tx_current_slot_pointer;
                  state_r <= ST_TSE;
               end
            end
            ST_TSE: begin
               if (!busMem) begin
                  state_r <= ST_TSE_W;
               end
            end
            ST_TSE_W: begin
               entry_r <= memQ;
               fetchIdx_r <= 2'd0;
               // Invalid entries are counted and dropped
               if (!memQ[`MTAM_TSE_VALID]) begin
                  skips_r <= skips_r + 32'h00000001;
                  state_r <= ST_IDLE;
               end else begin
                  state_r <= ST_FETCH;
               end
            end
            ST_FETCH: begin
               if (!busMem) begin
                  state_r <= ST_FETCH_W;
               end
            end
            ST_FETCH_W: begin
               // Globals first, then offset, index and length words of the channel
               case (fetchIdx_r)
                  2'd0: glbBase_r <= memQ;
                  2'd1: offW_r <= memQ;
                  2'd2: idxW_r <= memQ;
                  default: lenW_r <= memQ;
               endcase
               fetchIdx_r <= fetchIdx_r + 2'd1;
               state_r <= (fetchIdx_r == 2'd3) ? ST_WBACK : ST_FETCH;
            end
            ST_WBACK: begin
               // Index write-back and the first host request leave together
               if (!busMem) begin
                  hostReq <= 1'b1;
                  hostAddr <= descAddr;
                  state_r <= ST_BD_LEN;
               end
            end
            ST_BD_LEN: begin
               // First descriptor word: buffer length in the low half
               if (hostAck) begin
                  bufLen_r <= hostRdData[15:0];
                  hostAddr <= hostAddr + `MTAM_BD_PTR_OFS;
                  state_r <= ST_BD_PTR;
               end
            end
            ST_BD_PTR: begin
               if (hostAck) begin
                  hostReq <= 1'b0;
                  xferValid <= 1'b1;
                  xferRx <= dirRx_r;
                  xferAddr <= hostRdData;
                  xferLen <= bufLen_r;
                  // Slots sharing a channel pointer land in the same channel
                  xferChan <= entry_r[`MTAM_TSE_CHAN_LSB +: 6];
                  xferSubMask <= entry_r[`MTAM_TSE_MASK_LSB +: 8];
                  slots_r <= slots_r + 32'h00000001;
                  state_r <= ST_IDLE;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // Busy also covers slots still queued
   always_ff @(posedge clk) begin
      if (rst) begin
         busy <= 1'b0;
      end else if (ce) begin
         busy <= (state_r != ST_IDLE) || rxPend_r || txPend_r;
      end
   end

   // Read path: register data or RAM word one cycle after the strobe
   always_ff @(posedge clk) begin
      if (rst) begin
         rdData_r <= 32'h00000000;
         readMem_r <= 1'b0;
      end else if (ce) begin
         readMem_r <= regRd & ~regSel;
         rdData_r <= 32'h00000000;
         if (regRd && regSel) begin
            case (regAddr)
               `MTAM_REG_CTRL: rdData_r <= {30'h0, large_r, enable_r};
               `MTAM_REG_PAGE: rdData_r <= {26'h0, page_r};
               `MTAM_REG_RXSTART: rdData_r <= {18'h0, rxStart_r};
               `MTAM_REG_TXSTART: rdData_r <= {18'h0, txStart_r};
               `MTAM_REG_STATUS: rdData_r <= {28'h0, ovrTx_r, ovrRx_r, txPend_r, busy};
               `MTAM_REG_SLOTS: rdData_r <= slots_r;
               `MTAM_REG_SKIPS: rdData_r <= skips_r;
               `MTAM_REG_RXSLOT: rdData_r <= {18'h0, rx_current_slot_pointer};
               `MTAM_REG_TXSLOT: rdData_r <= {18'h0, tx_current_slot_pointer};
               default: rdData_r <= 32'h00000000;
            endcase
         end
      end
   end

   assign regRdData = readMem_r ? memQ : rdData_r;
endmodule // mtam_top

// file: testbench/mtam_top_sva.sv
`timescale 1ns/1ps
`include "mtam_defines.svh"
module mtam_top_sva (
   input wire logic clk,
   input wire logic rst,
   input wire logic [15:0] regAddr,
   input wire logic regRd,
   input wire logic [31:0] regRdData,
   input wire logic hostReq,
   input wire logic [31:0] hostAddr,
   input wire logic hostAck,
   input wire logic [31:0] hostRdData,
   input wire logic xferValid,
   input wire logic [31:0] xferAddr,
   input wire logic [15:0] xferLen
);
   logic phase_r;
   logic [15:0] lenCap_r;
   logic [31:0] ptrCap_r;
   wire hostTake = hostReq && hostAck;
   // Phase tells the length word from the buffer pointer word
   always_ff @(posedge clk) begin
      if (rst) phase_r <= 1'b0;
      else if (hostTake) phase_r <= !phase_r;
   end
   always_ff @(posedge clk) begin
      if (hostTake && !phase_r) lenCap_r <= hostRdData[15:0];
      if (hostTake && phase_r) ptrCap_r <= hostRdData;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_req_held: assert property (hostReq && !hostAck |=> hostReq && $stable(hostAddr))
      else $error("host request moved before ack");
   a_word_step: assert property (hostTake && !phase_r |=> hostReq && hostAddr == $past(hostAddr) + 32'h4)
      else $error("second descriptor word not at next word");
   a_req_gone: assert property (hostTake && phase_r |=> !hostReq)
      else $error("host request after pointer word");
   a_xfer_follow: assert property (hostTake && phase_r |-> ##[1:2] xferValid)
      else $error("no transfer after pointer word");
   a_xfer_single: assert property (xferValid |=> !xferValid)
      else $error("transfer pulse too long");
   a_req_no_xfer: assert property (hostReq |-> !xferValid)
      else $error("transfer during descriptor fetch");
   a_len_taken: assert property (xferValid |-> xferLen == lenCap_r)
      else $error("length not from descriptor");
   a_ptr_taken: assert property (xferValid |-> xferAddr == ptrCap_r)
      else $error("buffer address not from descriptor");
   a_page_field: assert property (regRd && regAddr == `MTAM_REG_PAGE |=> regRdData[31:6] == 26'h0)
      else $error("page index too wide");
   a_slot_range: assert property (regRd && regAddr == `MTAM_REG_RXSLOT |=> regRdData[31:14] == 18'h0)
      else $error("slot pointer outside RAM");
endmodule // mtam_top_sva
bind mtam_top mtam_top_sva mtam_top_sva_inst (.clk(clk), .rst(rst), .regAddr(regAddr),
   .regRd(regRd), .regRdData(regRdData), .hostReq(hostReq), .hostAddr(hostAddr),
   .hostAck(hostAck), .hostRdData(hostRdData), .xferValid(xferValid), .xferAddr(xferAddr),
   .xferLen(xferLen));

// file: testbench/mtam_host_model.sv
`timescale 1ns/1ps
module mtam_host_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic [5:0] delay,
   input wire logic hostReq,
   input wire logic [31:0] hostAddr,
   output logic hostAck,
   output logic [31:0] hostRdData
);
   logic [5:0] wait_r;
   // Word content is tied to its address; data toggles when not answering
   always_ff @(posedge clk) begin
      hostAck <= 1'b0;
      hostRdData <= ~hostRdData;
      if (rst) begin
         wait_r <= 6'h00;
         hostRdData <= 32'h0;
      end else if (hostReq && !hostAck) begin
         if (wait_r >= delay) begin
            hostAck <= 1'b1;
            hostRdData <= {~hostAddr[15:0], hostAddr[15:0]};
            wait_r <= 6'h00;
         end else begin
            wait_r <= wait_r + 6'h01;
         end
      end
   end
endmodule // mtam_host_model

// file: testbench/mtam_top_bench.sv
`timescale 1ns/1ps
`include "mtam_defines.svh"
module mtam_top_bench;
   localparam logic [31:0] BASE = 32'h00010000;
   logic clk, rst, regWr, regRd, rxSlotClk, rxFrameSync, txSlotClk, txFrameSync;
   logic hostReq, hostAck, xferValid, xferRx, busy;
   logic [15:0] regAddr, xferLen;
   logic [31:0] regWrData, regRdData, hostAddr, hostRdData, xferAddr;
   logic [5:0] xferChan, delay;
   logic [7:0] xferSubMask;
   logic [62:0] got;
   int nErrors = 0;
   int testsRun = 0;
   int nXfer = 0;
   mtam_top mtam_top_inst (.clk(clk), .rst(rst), .ce(1'b1), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
      .rxSlotClk(rxSlotClk), .rxFrameSync(rxFrameSync), .txSlotClk(txSlotClk),
      .txFrameSync(txFrameSync), .hostReq(hostReq), .hostAddr(hostAddr),
      .hostAck(hostAck), .hostRdData(hostRdData), .xferValid(xferValid), .xferRx(xferRx),
      .xferAddr(xferAddr), .xferLen(xferLen), .xferChan(xferChan),
      .xferSubMask(xferSubMask), .busy(busy));
   mtam_host_model mtam_host_model_inst (.clk(clk), .rst(rst), .delay(delay),
      .hostReq(hostReq), .hostAddr(hostAddr), .hostAck(hostAck), .hostRdData(hostRdData));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (xferValid === 1'b1) begin
         nXfer <= nXfer + 1;
         got <= {xferRx, xferChan, xferSubMask, xferLen, xferAddr};
      end
   end
   task automatic completeRun();
      if (nErrors == 0 && testsRun > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic check(string n, logic [63:0] s, logic [63:0] e);
      testsRun++;
      if (s !== e) begin
         nErrors++;
         $display("Error %s: expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(logic [15:0] a, logic [31:0] d);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic ram(logic [13:0] a, logic [31:0] d);
      wr({2'b10, a}, d);
   endtask
   task automatic rdChk(string n, logic [15:0] a, logic [31:0] e);
      logic [31:0] d;
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 d = regRdData;
      @(posedge clk);
      check(n, {32'h0, d}, {32'h0, e});
   endtask
   task automatic slot(logic tx, logic sync);
      if (tx) begin
         txSlotClk <= 1'b1;
         txFrameSync <= sync;
      end else begin
         rxSlotClk <= 1'b1;
         rxFrameSync <= sync;
      end
      repeat (4) @(posedge clk);
      {rxSlotClk, txSlotClk, rxFrameSync, txFrameSync} <= 4'h0;
      repeat (4) @(posedge clk);
   endtask
   task automatic waitIdle();
      int t;
      for (t = 0; t < 300 && busy !== 1'b0; t++) @(posedge clk);
      if (busy !== 1'b0) nErrors++;
   endtask
   task automatic doXfer(logic tx, logic sync, string n, logic [7:0] m, logic [31:0] d);
      int n0;
      int t;
      logic [31:0] p;
      n0 = nXfer;
      p = d + 32'h4;
      slot(tx, sync);
      check("busy", 64'(busy), 64'h1);
      for (t = 0; t < 300 && nXfer == n0; t++) @(posedge clk);
      if (nXfer == n0) nErrors++;
      check(n, {1'b0, got}, {1'b0, !tx, 6'd8, m, d[15:0], ~p[15:0], p[15:0]});
   endtask
   task automatic tResetVals();
      rdChk("ctrl", `MTAM_REG_CTRL, 32'h0);
      rdChk("rx start", `MTAM_REG_RXSTART, 32'h14);
      rdChk("tx start", `MTAM_REG_TXSTART, 32'h3C);
      rdChk("unmapped", 16'h0040, 32'h0);
   endtask
   task automatic tDisabled();
      slot(1'b0, 1'b1);
      waitIdle();
      check("idle xfers", 64'(nXfer), 64'h0);
      rdChk("idle skips", `MTAM_REG_SKIPS, 32'h0);
   endtask
   task automatic setup();
      wr(`MTAM_REG_CTRL, 32'h3);
      wr(`MTAM_REG_PAGE, 32'h1);
      wr(`MTAM_REG_RXSTART, 32'h114);
      wr(`MTAM_REG_TXSTART, 32'h13C);
      ram(14'h100, BASE);
      ram(14'h108, 32'h00008000);
      ram(14'h114, 32'hF0008200);
      ram(14'h118, 32'hF0008200);
      ram(14'h11C, 32'h00000200);
      ram(14'h13C, 32'h0F008200);
      ram(14'h200, 32'h02000100);
      ram(14'h204, 32'h0);
      ram(14'h208, 32'h00180010);
   endtask
   task automatic tRxSlots();
      doXfer(1'b0, 1'b1, "rx slot0", 8'hF0, BASE + 32'h100);
      doXfer(1'b0, 1'b0, "rx slot1", 8'hF0, BASE + 32'h108);
      slot(1'b0, 1'b0);
      waitIdle();
      rdChk("skips", `MTAM_REG_SKIPS, 32'h1);
      check("rx xfers", 64'(nXfer), 64'h2);
      rdChk("rx ptr", `MTAM_REG_RXSLOT, 32'h11C);
      rdChk("rx wrap", 16'h8204, 32'h0);
   endtask
   task automatic tTxSlot();
      delay <= 6'd7;
      doXfer(1'b1, 1'b1, "tx slot0", 8'h0F, BASE + 32'h200);
      rdChk("tx ptr", `MTAM_REG_TXSLOT, 32'h13C);
      delay <= 6'd0;
   endtask
   task automatic tShared();
      wr(`MTAM_REG_TXSTART, 32'h114);
      doXfer(1'b1, 1'b1, "shared", 8'hF0, BASE + 32'h208);
      rdChk("idx", 16'h8204, 32'h00100000);
      rdChk("slots", `MTAM_REG_SLOTS, 32'h4);
      rdChk("page", `MTAM_REG_PAGE, 32'h1);
   endtask
   task automatic tSmallOverrun();
      wr(`MTAM_REG_CTRL, 32'h1);
      wr(`MTAM_REG_TXSTART, 32'h2114);
      doXfer(1'b1, 1'b1, "small mask", 8'hF0, BASE + 32'h210);
      delay <= 6'h3F;
      slot(1'b1, 1'b1);
      slot(1'b1, 1'b0);
      slot(1'b1, 1'b0);
      rdChk("overrun", `MTAM_REG_STATUS, 32'hB);
      wr(`MTAM_REG_STATUS, 32'h8);
      rdChk("ovr clear", `MTAM_REG_STATUS, 32'h3);
      waitIdle();
      rdChk("drained", `MTAM_REG_STATUS, 32'h0);
      rdChk("state word", 16'h8108, 32'h8000);
      delay <= 6'h00;
   endtask
   initial begin
      rst = 1'b1;
      {regWr, regRd, rxSlotClk, rxFrameSync, txSlotClk, txFrameSync} = 6'h00;
      regAddr = 16'h0;
      regWrData = 32'h0;
      delay = 6'd0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      tResetVals();
      tDisabled();
      setup();
      tRxSlots();
      tTxSlot();
      tShared();
      tSmallOverrun();
      completeRun();
   end
   initial begin
      repeat (20000) @(posedge clk);
      nErrors++;
      completeRun();
   end
endmodule // mtam_top_bench
